//--- rtl/rxvm_port_bank.sv
// Per-port identifier, channel remap and line monitor registers behind the target register port.
//
// How it works
// - Each port's copy chosen by port select.
// - RAW12 packets tagged with channel field.
// - RAW12 channel resets to port number.
// - RAW12 data type field, reset 0x2C.
// - RAW12 settings used only in RAW12 modes.
// - Remapping applies only in CSI-2 mode.
// - Incoming channel replaced by remap lookup.
// - Four two-bit entries, channel 3 on top.
// - Lines per frame counted, 16-bit split.
// - Line count frozen until read when enabled.
// - High byte read latches line count low.
// - Line length measured; last line reported.
// - Line length frozen until read when enabled.
// - High byte read latches line length low.
// - Mode 00 CSI-2, 01/10 RAW12, 11 RAW10.
// - RAW10 uses own channel and type.
`timescale 1ns/1ps
module rxvm_port_bank #(
    parameter int PORT_COUNT = 2
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire rxvm_pkg::rxvm_reg_req_type reg_req_i,
    output logic [7:0] reg_rdata_o,
    // Port configuration from the port config register
    input wire logic [PORT_COUNT-1:0][1:0] port_input_mode_i,
    input wire logic [PORT_COUNT-1:0] line_total_change_irq_enable_i,
    input wire logic [PORT_COUNT-1:0] line_width_change_irq_enable_i,
    // Incoming video per port
    input wire rxvm_pkg::rxvm_pkt_type [PORT_COUNT-1:0] csi_pkt_i,
    input wire logic [PORT_COUNT-1:0] raw_pkt_valid_i,
    input wire logic [PORT_COUNT-1:0] frame_end_i,
    input wire logic [PORT_COUNT-1:0] line_start_i,
    input wire logic [PORT_COUNT-1:0] line_end_i,
    input wire logic [PORT_COUNT-1:0] pixel_valid_i,
    // Outgoing packet tags per port
    output rxvm_pkg::rxvm_pkt_type [PORT_COUNT-1:0] out_pkt_o
);

    // The select field is three bits wide, so at most eight ports can be reached.
    if (PORT_COUNT < 1 || PORT_COUNT > 8) begin : g_bad_port_count
        $error("PORT_COUNT must lie between 1 and 8");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] remap_lookup(input logic [7:0] map, input logic [1:0] vc);
        remap_lookup = map[{vc, 1'b0} +: 2];
    endfunction : remap_lookup

    function automatic logic is_raw12(input logic [1:0] mode);
        is_raw12 = (mode == rxvm_pkg::RXVM_MODE_RAW12_LOW) || (mode == rxvm_pkg::RXVM_MODE_RAW12_HIGH);
    endfunction : is_raw12

    // ------------------------------------------------------------
    // Port select
    // ------------------------------------------------------------
    logic [7:0] port_select;
    logic [2:0] sel;
    logic wr_en;
    logic rd_en;

    assign wr_en = reg_req_i.write;
    assign rd_en = reg_req_i.read;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            port_select <= 8'h00;
        end else if (wr_en && reg_req_i.addr == rxvm_pkg::PORT_SELECT_ADDR) begin
            port_select <= reg_req_i.wdata;
        end
    end

    // The low bits of the select register name the port whose copy is accessed.
    assign sel = port_select[2:0];

    // ------------------------------------------------------------
    // Per-port registers
    // ------------------------------------------------------------
    logic [PORT_COUNT-1:0][7:0] raw10_ident;
    logic [PORT_COUNT-1:0][7:0] raw12_stream_ident;
    logic [PORT_COUNT-1:0][7:0] virtual_channel_remap;
    logic [PORT_COUNT-1:0][15:0] line_total_shown;
    logic [PORT_COUNT-1:0][15:0] line_width_shown;
    logic [PORT_COUNT-1:0][15:0] line_counter;
    logic [PORT_COUNT-1:0][15:0] width_counter;
    logic [PORT_COUNT-1:0][15:0] last_width;
    logic [PORT_COUNT-1:0] total_frozen;
    logic [PORT_COUNT-1:0] width_frozen;
    logic [PORT_COUNT-1:0] total_hi_read;
    logic [PORT_COUNT-1:0] width_hi_read;
    logic [PORT_COUNT-1:0][7:0] total_low_latch;
    logic [PORT_COUNT-1:0][7:0] width_low_latch;

    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        logic hit;
        logic total_done;
        logic width_done;
        logic total_capture;
        logic width_capture;
        logic total_armed;
        logic width_armed;
        logic [15:0] next_line_count;
        logic [15:0] next_width;

        assign hit = (sel == 3'(p));

        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                raw12_stream_ident[p] <= {2'(p), rxvm_pkg::RAW12_TYPE_RESET};
                raw10_ident[p] <= {2'(p), rxvm_pkg::RAW10_TYPE_RESET};
                virtual_channel_remap[p] <= rxvm_pkg::VC_REMAP_RESET;
            end else if (wr_en && hit) begin
                if (reg_req_i.addr == rxvm_pkg::RAW12_IDENT_ADDR) begin
                    raw12_stream_ident[p] <= reg_req_i.wdata;
                end
                if (reg_req_i.addr == rxvm_pkg::RAW10_IDENT_ADDR) begin
                    raw10_ident[p] <= reg_req_i.wdata;
                end
                if (reg_req_i.addr == rxvm_pkg::VC_REMAP_ADDR) begin
                    virtual_channel_remap[p] <= reg_req_i.wdata;
                end
            end
        end

        // Line counting within the frame.
        assign next_line_count = line_counter[p] + 16'h0001;
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i || frame_end_i[p]) begin
                line_counter[p] <= 16'h0000;
            end else if (line_end_i[p]) begin
                line_counter[p] <= next_line_count;
            end
        end

        // Pixel counting within the line; the last completed line wins.
        assign next_width = width_counter[p] + 16'h0001;
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i || line_start_i[p]) begin
                width_counter[p] <= 16'h0000;
            end else if (pixel_valid_i[p]) begin
                width_counter[p] <= next_width;
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                last_width[p] <= rxvm_pkg::MEASURE_RESET;
            end else if (line_end_i[p]) begin
                last_width[p] <= width_counter[p];
            end
        end

        // ------------------------------------------------------------
        // Freeze and release
        // ------------------------------------------------------------
        assign total_capture = frame_end_i[p] && !total_frozen[p];
        assign width_capture = frame_end_i[p] && !width_frozen[p];

        // A release needs a high read of the captured value and then a low read.
        // A high read taken before a capture saw the old value, so the capture disarms the release.
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i || total_capture) begin
                total_armed <= 1'b0;
            end else if (rd_en && hit && reg_req_i.addr == rxvm_pkg::LINE_TOTAL_HIGH_ADDR) begin
                total_armed <= 1'b1;
            end else if (rd_en && hit && reg_req_i.addr == rxvm_pkg::LINE_TOTAL_LOW_ADDR) begin
                total_armed <= 1'b0;
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i || width_capture) begin
                width_armed <= 1'b0;
            end else if (rd_en && hit && reg_req_i.addr == rxvm_pkg::LINE_WIDTH_HIGH_ADDR) begin
                width_armed <= 1'b1;
            end else if (rd_en && hit && reg_req_i.addr == rxvm_pkg::LINE_WIDTH_LOW_ADDR) begin
                width_armed <= 1'b0;
            end
        end

        assign total_done = rd_en && hit && total_armed && reg_req_i.addr == rxvm_pkg::LINE_TOTAL_LOW_ADDR;
        assign width_done = rd_en && hit && width_armed && reg_req_i.addr == rxvm_pkg::LINE_WIDTH_LOW_ADDR;

        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                line_total_shown[p] <= rxvm_pkg::MEASURE_RESET;
                total_frozen[p] <= 1'b0;
            end else if (total_capture) begin
                line_total_shown[p] <= line_end_i[p] ? next_line_count : line_counter[p];
                total_frozen[p] <= line_total_change_irq_enable_i[p];
            end else if (total_done || !line_total_change_irq_enable_i[p]) begin
                total_frozen[p] <= 1'b0;
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                line_width_shown[p] <= rxvm_pkg::MEASURE_RESET;
                width_frozen[p] <= 1'b0;
            end else if (width_capture) begin
                line_width_shown[p] <= line_end_i[p] ? width_counter[p] : last_width[p];
                width_frozen[p] <= line_width_change_irq_enable_i[p];
            end else if (width_done || !line_width_change_irq_enable_i[p]) begin
                width_frozen[p] <= 1'b0;
            end
        end

        // High byte reads capture the low byte for a coherent pair.
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                total_low_latch[p] <= 8'h00;
                width_low_latch[p] <= 8'h00;
                total_hi_read[p] <= 1'b0;
                width_hi_read[p] <= 1'b0;
            end else if (rd_en && hit) begin
                if (reg_req_i.addr == rxvm_pkg::LINE_TOTAL_HIGH_ADDR) begin
                    total_low_latch[p] <= line_total_shown[p][7:0];
                    total_hi_read[p] <= 1'b1;
                end else if (reg_req_i.addr == rxvm_pkg::LINE_TOTAL_LOW_ADDR) begin
                    total_hi_read[p] <= 1'b0;
                end
                if (reg_req_i.addr == rxvm_pkg::LINE_WIDTH_HIGH_ADDR) begin
                    width_low_latch[p] <= line_width_shown[p][7:0];
                    width_hi_read[p] <= 1'b1;
                end else if (reg_req_i.addr == rxvm_pkg::LINE_WIDTH_LOW_ADDR) begin
                    width_hi_read[p] <= 1'b0;
                end
            end
        end

        // ------------------------------------------------------------
        // Outgoing tag
        // ------------------------------------------------------------
        always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
                out_pkt_o[p] <= '0;
            end else begin
                case (port_input_mode_i[p])
                    rxvm_pkg::RXVM_MODE_CSI2: begin
                        out_pkt_o[p].valid <= csi_pkt_i[p].valid;
                        out_pkt_o[p].channel <= remap_lookup(virtual_channel_remap[p], csi_pkt_i[p].channel);
                        out_pkt_o[p].data_type <= csi_pkt_i[p].data_type;
                    end
                    rxvm_pkg::RXVM_MODE_RAW10: begin
                        out_pkt_o[p].valid <= raw_pkt_valid_i[p];
                        out_pkt_o[p].channel <= raw10_ident[p][rxvm_pkg::CHANNEL_MSB:rxvm_pkg::CHANNEL_LSB];
                        out_pkt_o[p].data_type <= raw10_ident[p][rxvm_pkg::TYPE_MSB:0];
                    end
                    default: begin
                        out_pkt_o[p].valid <= raw_pkt_valid_i[p] && is_raw12(port_input_mode_i[p]);
                        out_pkt_o[p].channel <= raw12_stream_ident[p][rxvm_pkg::CHANNEL_MSB:rxvm_pkg::CHANNEL_LSB];
                        out_pkt_o[p].data_type <= raw12_stream_ident[p][rxvm_pkg::TYPE_MSB:0];
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (reg_req_i.addr == rxvm_pkg::PORT_SELECT_ADDR) begin
            next_rdata = port_select;
        end else begin
            for (int i = 0; i < PORT_COUNT; i++) begin
                if (sel == 3'(i)) begin
                    case (reg_req_i.addr)
                        rxvm_pkg::RAW10_IDENT_ADDR: next_rdata = raw10_ident[i];
                        rxvm_pkg::RAW12_IDENT_ADDR: next_rdata = raw12_stream_ident[i];
                        rxvm_pkg::VC_REMAP_ADDR: next_rdata = virtual_channel_remap[i];
                        rxvm_pkg::LINE_TOTAL_HIGH_ADDR: next_rdata = line_total_shown[i][15:8];
                        rxvm_pkg::LINE_TOTAL_LOW_ADDR: next_rdata = total_hi_read[i] ? total_low_latch[i]
                                                                  : line_total_shown[i][7:0];
                        rxvm_pkg::LINE_WIDTH_HIGH_ADDR: next_rdata = line_width_shown[i][15:8];
                        rxvm_pkg::LINE_WIDTH_LOW_ADDR: next_rdata = width_hi_read[i] ? width_low_latch[i]
                                                                  : line_width_shown[i][7:0];
                        default: next_rdata = 8'h00;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (rd_en) begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule : rxvm_port_bank

//--- rtl/rxvm_pkg.sv
// Package with register map, field layout and types of the receive port remap and line monitor block.
package rxvm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_SELECT_ADDR = 8'h4c;
    localparam logic [7:0] RAW10_IDENT_ADDR = 8'h70;
    localparam logic [7:0] RAW12_IDENT_ADDR = 8'h71;
    localparam logic [7:0] VC_REMAP_ADDR = 8'h72;
    localparam logic [7:0] LINE_TOTAL_HIGH_ADDR = 8'h73;
    localparam logic [7:0] LINE_TOTAL_LOW_ADDR = 8'h74;
    localparam logic [7:0] LINE_WIDTH_HIGH_ADDR = 8'h75;
    localparam logic [7:0] LINE_WIDTH_LOW_ADDR = 8'h76;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CHANNEL_MSB = 7;
    localparam int CHANNEL_LSB = 6;
    localparam int TYPE_MSB = 5;
    localparam logic [5:0] RAW12_TYPE_RESET = 6'h2c;
    localparam logic [5:0] RAW10_TYPE_RESET = 6'h2b;
    localparam logic [7:0] VC_REMAP_RESET = 8'he4;
    localparam logic [15:0] MEASURE_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RXVM_MODE_CSI2 = 2'h0,
        RXVM_MODE_RAW12_LOW = 2'h1,
        RXVM_MODE_RAW12_HIGH = 2'h2,
        RXVM_MODE_RAW10 = 2'h3
    } rxvm_mode_type;

    typedef struct packed {
        logic valid;
        logic [1:0] channel;
        logic [5:0] data_type;
    } rxvm_pkt_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rxvm_reg_req_type;

endpackage : rxvm_pkg

//--- verif/rxvm_port_bank_asserts.sv
// Port-level assertions for the receive port remap and line monitor bank, with its bind.
`timescale 1ns/1ps
module rxvm_port_bank_asserts #(
    parameter int PORT_COUNT = 2
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire rxvm_pkg::rxvm_reg_req_type reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    // Video side
    input wire logic [PORT_COUNT-1:0][1:0] port_input_mode_i,
    input wire rxvm_pkg::rxvm_pkt_type [PORT_COUNT-1:0] csi_pkt_i,
    input wire logic [PORT_COUNT-1:0] raw_pkt_valid_i,
    input wire rxvm_pkg::rxvm_pkt_type [PORT_COUNT-1:0] out_pkt_o
);
    // Shadow of the first port's writable registers, followed from the write requests.
    logic [2:0] sel;
    logic [7:0] map0;
    logic [7:0] id12;
    logic [7:0] id10;
    logic [1:0] mode0;
    logic wr0;
    assign mode0 = port_input_mode_i[0];
    assign wr0 = reg_req_i.write && sel == 3'h0;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sel <= 3'h0;
            map0 <= rxvm_pkg::VC_REMAP_RESET;
            id12 <= {2'h0, rxvm_pkg::RAW12_TYPE_RESET};
            id10 <= {2'h0, rxvm_pkg::RAW10_TYPE_RESET};
        end else begin
            if (reg_req_i.write && reg_req_i.addr == rxvm_pkg::PORT_SELECT_ADDR) sel <= reg_req_i.wdata[2:0];
            if (wr0 && reg_req_i.addr == rxvm_pkg::VC_REMAP_ADDR) map0 <= reg_req_i.wdata;
            if (wr0 && reg_req_i.addr == rxvm_pkg::RAW12_IDENT_ADDR) id12 <= reg_req_i.wdata;
            if (wr0 && reg_req_i.addr == rxvm_pkg::RAW10_IDENT_ADDR) id10 <= reg_req_i.wdata;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_csi0;
        csi_pkt_i[0].valid && mode0 == 2'h0;
    endsequence
    sequence s_raw12;
        raw_pkt_valid_i[0] && (mode0 == 2'h1 || mode0 == 2'h2);
    endsequence
    a_reset_quiet: assert property ($fell(sys_rst_i) |-> reg_rdata_o == 8'h00 && out_pkt_o == '0)
        else $error("outputs not clear after reset");
    a_rdata_hold: assert property (!reg_req_i.read |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_csi_remap: assert property (s_csi0 |=> out_pkt_o[0].valid &&
        out_pkt_o[0].channel == 2'($past(map0 >> {csi_pkt_i[0].channel, 1'b0})) &&
        out_pkt_o[0].data_type == $past(csi_pkt_i[0].data_type)) else $error("csi channel not remapped");
    a_raw12_tag: assert property (s_raw12 |=> out_pkt_o[0] == {1'b1, $past(id12)})
        else $error("raw12 tag wrong");
    a_raw10_tag: assert property (raw_pkt_valid_i[0] && mode0 == 2'h3 |=> out_pkt_o[0] == {1'b1, $past(id10)})
        else $error("raw10 tag wrong");
    a_out_quiet: assert property (!raw_pkt_valid_i[0] && !(csi_pkt_i[0].valid && mode0 == 2'h0)
        |=> !out_pkt_o[0].valid) else $error("tag without a packet");
    a_map_read: assert property (reg_req_i.read && sel == 3'h0 && reg_req_i.addr == 8'h72
        |=> reg_rdata_o == $past(map0)) else $error("remap read wrong");
    a_ident_read: assert property (reg_req_i.read && sel == 3'h0 && reg_req_i.addr == 8'h71
        |=> reg_rdata_o == $past(id12)) else $error("raw12 ident read wrong");
    a_unmapped_read: assert property (reg_req_i.read && !(reg_req_i.addr inside {8'h4c, [8'h70:8'h76]})
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule : rxvm_port_bank_asserts
bind rxvm_port_bank rxvm_port_bank_asserts #(.PORT_COUNT(PORT_COUNT)) u_asserts (.core_clk_i, .sys_rst_i,
    .reg_req_i, .reg_rdata_o, .port_input_mode_i, .csi_pkt_i, .raw_pkt_valid_i, .out_pkt_o);

//--- verif/rxvm_video_src.sv
// Behavioural remote serializer sending packet headers, lines and frames into the bank.
`timescale 1ns/1ps
module rxvm_video_src #(
    parameter int PORT_COUNT = 2
) (
    // Clock
    input wire logic core_clk_i,
    // Video toward the bank
    output rxvm_pkg::rxvm_pkt_type [PORT_COUNT-1:0] csi_pkt_o,
    output logic [PORT_COUNT-1:0] raw_pkt_valid_o,
    output logic [PORT_COUNT-1:0] frame_end_o,
    output logic [PORT_COUNT-1:0] line_start_o,
    output logic [PORT_COUNT-1:0] line_end_o,
    output logic [PORT_COUNT-1:0] pixel_valid_o
);
    initial begin
        csi_pkt_o = '0;
        {raw_pkt_valid_o, frame_end_o, line_start_o, line_end_o, pixel_valid_o} = '0;
    end
    task send_pkt(input int p, input logic raw, input logic [1:0] ch, input logic [5:0] dt);
        @(posedge core_clk_i);
        if (raw) raw_pkt_valid_o[p] <= 1'b1;
        else csi_pkt_o[p] <= {1'b1, ch, dt};
        @(posedge core_clk_i);
        raw_pkt_valid_o[p] <= 1'b0;
        csi_pkt_o[p] <= '0;
    endtask : send_pkt
    // Earlier lines are three pixels longer than the last, so only the last length may show.
    task send_frame(input int p, input int n, input int w);
        for (int l = 0; l < n; l++) begin
            @(posedge core_clk_i) line_start_o[p] <= 1'b1;
            @(posedge core_clk_i) line_start_o[p] <= 1'b0;
            pixel_valid_o[p] <= 1'b1;
            repeat ((l == n - 1) ? w : w + 3) @(posedge core_clk_i);
            pixel_valid_o[p] <= 1'b0;
            line_end_o[p] <= 1'b1;
            frame_end_o[p] <= (l == n - 1);
            @(posedge core_clk_i) line_end_o[p] <= 1'b0;
            frame_end_o[p] <= 1'b0;
        end
    endtask : send_frame
endmodule : rxvm_video_src

//--- verif/tb.sv
// Self-checking bench for the receive port remap and line monitor bank.
`timescale 1ns/1ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin failures++; $display("BAD %0t %s", $time, m); end end
module tb;
    logic core_clk_i;
    logic sys_rst_i;
    rxvm_pkg::rxvm_reg_req_type req;
    logic [7:0] rdata;
    logic [1:0][1:0] mode;
    logic [1:0] cnt_fz, wid_fz, raw, fe, ls, le, pv;
    rxvm_pkg::rxvm_pkt_type [1:0] csi, out;
    int failures = 0;
    int compares = 0;
    rxvm_port_bank #(.PORT_COUNT(2)) uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .port_input_mode_i(mode), .line_total_change_irq_enable_i(cnt_fz),
        .line_width_change_irq_enable_i(wid_fz), .csi_pkt_i(csi), .raw_pkt_valid_i(raw), .frame_end_i(fe),
        .line_start_i(ls), .line_end_i(le), .pixel_valid_i(pv), .out_pkt_o(out));
    rxvm_video_src #(.PORT_COUNT(2)) src (.core_clk_i(core_clk_i), .csi_pkt_o(csi), .raw_pkt_valid_o(raw),
        .frame_end_o(fe), .line_start_o(ls), .line_end_o(le), .pixel_valid_o(pv));
    task end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i) req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk_i) req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk_i) req <= '0;
        #1 `CHK(rdata, e, "register read")
    endtask : rd
    task set_cfg(input int p, input logic [1:0] m, input logic f);
        @(posedge core_clk_i) mode[p] <= m;
        cnt_fz[p] <= f;
        wid_fz[p] <= f;
    endtask : set_cfg
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        #2000000;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        sys_rst_i = 1'b1;
        req = '0;
        mode = '0;
        cnt_fz = '0;
        wid_fz = '0;
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            wr(8'h4c, 8'(p));
            rd(8'h71, {2'(p), rxvm_pkg::RAW12_TYPE_RESET});
            rd(8'h70, {2'(p), rxvm_pkg::RAW10_TYPE_RESET});
            rd(8'h72, rxvm_pkg::VC_REMAP_RESET);
            for (int a = 8'h73; a <= 8'h76; a++) rd(8'(a), 8'h00);
        end
        wr(8'h73, 8'hff);
        rd(8'h73, 8'h00);
        wr(8'h72, 8'h1b);
        wr(8'h4c, 8'h05);
        rd(8'h72, 8'h00);
        rd(8'h7f, 8'h00);
        $display("test registers done");
        for (int p = 0; p < 2; p++) for (int c = 0; c < 4; c++) begin
            src.send_pkt(p, 1'b0, 2'(c), 6'h2a);
            #1 `CHK(out[p], {1'b1, (p == 1) ? 2'(3 - c) : 2'(c), 6'h2a}, "remap")
        end
        set_cfg(0, 2'h3, 1'b0);
        src.send_pkt(0, 1'b0, 2'h1, 6'h2a);
        #1 `CHK(out[0].valid, 1'b0, "remap in raw mode")
        src.send_pkt(0, 1'b1, 2'h0, 6'h00);
        #1 `CHK(out[0], {1'b1, 2'h0, 6'h2b}, "raw10 tag")
        wr(8'h4c, 8'h00);
        wr(8'h71, 8'hd5);
        for (int m = 1; m < 3; m++) begin
            set_cfg(0, 2'(m), 1'b0);
            src.send_pkt(0, 1'b1, 2'h0, 6'h00);
            #1 `CHK(out[0], {1'b1, 8'hd5}, "raw12 tag")
        end
        set_cfg(0, 2'h0, 1'b0);
        src.send_pkt(0, 1'b0, 2'h2, 6'h2a);
        #1 `CHK(out[0], {1'b1, 2'h2, 6'h2a}, "raw12 unused in csi")
        $display("test tags done");
        src.send_frame(0, 5, 4);
        rd(8'h73, 8'h00);
        rd(8'h74, 8'h05);
        rd(8'h75, 8'h00);
        rd(8'h76, 8'h04);
        src.send_frame(0, 260, 3);
        rd(8'h73, 8'h01);
        src.send_frame(0, 5, 4);
        rd(8'h74, 8'h04);
        src.send_frame(0, 2, 257);
        rd(8'h75, 8'h01);
        src.send_frame(0, 3, 9);
        rd(8'h76, 8'h01);
        $display("test measure done");
        set_cfg(0, 2'h0, 1'b1);
        src.send_frame(0, 3, 2);
        src.send_frame(0, 4, 5);
        rd(8'h73, 8'h00);
        rd(8'h74, 8'h03);
        rd(8'h75, 8'h00);
        rd(8'h76, 8'h02);
        src.send_frame(0, 6, 7);
        rd(8'h73, 8'h00);
        src.send_frame(0, 2, 1);
        rd(8'h73, 8'h00);
        rd(8'h74, 8'h06);
        src.send_frame(0, 2, 1);
        rd(8'h74, 8'h02);
        rd(8'h73, 8'h00);
        rd(8'h74, 8'h02);
        rd(8'h75, 8'h00);
        rd(8'h76, 8'h07);
        rd(8'h73, 8'h00);
        src.send_frame(0, 3, 1);
        rd(8'h74, 8'h02);
        src.send_frame(0, 4, 2);
        rd(8'h73, 8'h00);
        rd(8'h74, 8'h03);
        set_cfg(0, 2'h0, 1'b0);
        src.send_frame(0, 2, 5);
        rd(8'h76, 8'h05);
        $display("test freeze done");
        end_sim();
    end
endmodule : tb
